// ==== cbi_consts.vh ====
// constants for the can buffer interrupt and error count block
// How it works
// - A 16-bit enable register holds one bit per message buffer, and a set bit lets that buffer interrupt.
// - The enable register has an upper byte and a lower byte, and the host may write the whole word or either byte alone.
// - A successful transfer on a buffer sets that buffer's pending flag.
// - A buffer requests an interrupt only while its pending flag and its enable bit are both set.
// - The pending register has an upper byte and a lower byte, and the host may access the whole word or either byte.
// - A pending flag clears only when the host has read it as one and then writes zero to it.
// - A new event that comes between that read and the zero write keeps the flag set.
// - Host writes to the pending register can only clear bits, and writing one never sets a bit.
// - The receive error count is readable as an 8-bit value.
// - The transmit error count is readable as an 8-bit value.
// - The transmit warning and receive warning statuses are high while their counts are at least 96.
// - The fault confinement state reads as a 2-bit code, 00 error active and 01 error passive.
`ifndef CBI_CONSTS_VH
`define CBI_CONSTS_VH
`define CBI_ADDR_W 4
`define CBI_OFF_ENABLE 4'h0
`define CBI_OFF_PENDING 4'h4
`define CBI_OFF_ERRCNT 4'h8
`define CBI_OFF_STATUS 4'hC
`define CBI_ENABLE_RST 16'h0000
`define CBI_PENDING_RST 16'h0000
`define CBI_WARN_LIMIT 8'h60
`define CBI_RESP_OKAY 2'b00
`define CBI_RESP_SLVERR 2'b10
`define CBI_ERRCNT_RX_LSB 0
`define CBI_ERRCNT_TX_LSB 8
`define CBI_STAT_TRANSMIT_WARNING 9
`define CBI_STAT_RECEIVE_WARNING 8
`define CBI_STAT_FCS_LSB 4
`endif

// ==== cbi_pend_flag.v ====
// one pending flag with read-then-zero clearing
`timescale 1ns/1ps
module cbi_pend_flag
(
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// events
	input wire set_i,
	input wire read_i,
	input wire wr_en_i,
	input wire wr_bit_i,
	// state
	output reg flag_o
);
reg armed_ff;
reg nxt_armed;
reg nxt_flag;
always @*
begin
	nxt_flag = flag_o;
	nxt_armed = armed_ff;
	if (read_i && flag_o)
		nxt_armed = 1'b1;
	if (wr_en_i && !wr_bit_i && armed_ff)
	begin
		nxt_flag = 1'b0;
		nxt_armed = 1'b0;
	end
	else if (wr_en_i)
		nxt_armed = 1'b0;
	if (set_i)
	begin
		nxt_flag = 1'b1;
		nxt_armed = 1'b0;
	end
end
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		flag_o <= 1'b0;
		armed_ff <= 1'b0;
	end
	else
	begin
		flag_o <= nxt_flag;
		armed_ff <= nxt_armed;
	end
end
endmodule // cbi_pend_flag

// ==== cbi_top.v ====
// can buffer interrupt flags, masks and error count readout over axi4-lite
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "cbi_consts.vh"
module cbi_top
(
	// clock and reset
	input wire SYS_CLK_I,
	input wire RST_I,
	// can core side
	input wire [15:0] BUF_DONE_I,
	input wire [7:0] RX_ERR_CNT_I,
	input wire [7:0] TX_ERR_CNT_I,
	input wire ERR_PASSIVE_I,
	output reg BUF_IRQ_O,
	output reg TRANSMIT_WARNING_O,
	output reg RECEIVE_WARNING_O,
	// axi write address
	input wire [`CBI_ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire S_AXI_AWVALID_I,
	output reg S_AXI_AWREADY_O,
	// axi write data
	input wire [31:0] S_AXI_WDATA_I,
	input wire [3:0] S_AXI_WSTRB_I,
	input wire S_AXI_WVALID_I,
	output reg S_AXI_WREADY_O,
	// axi write response
	output reg [1:0] S_AXI_BRESP_O,
	output reg S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	// axi read address
	input wire [`CBI_ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire S_AXI_ARVALID_I,
	output reg S_AXI_ARREADY_O,
	// axi read data
	output reg [31:0] S_AXI_RDATA_O,
	output reg [1:0] S_AXI_RRESP_O,
	output reg S_AXI_RVALID_O,
	input wire S_AXI_RREADY_I
);
function is_mapped;
	input [`CBI_ADDR_W-1:0] a;
	begin
		is_mapped = (a == `CBI_OFF_ENABLE) || (a == `CBI_OFF_PENDING) ||
			(a == `CBI_OFF_ERRCNT) || (a == `CBI_OFF_STATUS);
	end
endfunction
reg [15:0] buffer_irq_enable_ff;
reg [15:0] nxt_enable;
wire [15:0] buffer_irq_pending;
reg [`CBI_ADDR_W-1:0] awaddr_ff;
reg aw_held_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg w_held_ff;
wire wr_go;
wire rd_go;
reg [31:0] rd_value;
reg [1:0] fault_confinement_state;
reg [15:0] pend_rd;
reg [15:0] pend_wr_en;
reg [15:0] pend_wr_bit;
// write path: address and data taken in either order
assign wr_go = aw_held_ff && w_held_ff && !S_AXI_BVALID_O;
assign rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
always @(posedge SYS_CLK_I)
begin
	if (RST_I)
	begin
		aw_held_ff <= 1'b0;
		w_held_ff <= 1'b0;
		awaddr_ff <= {`CBI_ADDR_W{1'b0}};
		wdata_ff <= 32'h00000000;
		wstrb_ff <= 4'h0;
		S_AXI_AWREADY_O <= 1'b0;
		S_AXI_WREADY_O <= 1'b0;
		S_AXI_BVALID_O <= 1'b0;
		S_AXI_BRESP_O <= `CBI_RESP_OKAY;
	end
	else
	begin
		S_AXI_AWREADY_O <= !aw_held_ff && !S_AXI_AWREADY_O && !S_AXI_BVALID_O;
		S_AXI_WREADY_O <= !w_held_ff && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
		begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= S_AXI_AWADDR_I;
			S_AXI_AWREADY_O <= 1'b0;
		end
		if (S_AXI_WVALID_I && S_AXI_WREADY_O)
		begin
			w_held_ff <= 1'b1;
			wdata_ff <= S_AXI_WDATA_I;
			wstrb_ff <= S_AXI_WSTRB_I;
			S_AXI_WREADY_O <= 1'b0;
		end
		if (wr_go)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			S_AXI_BVALID_O <= 1'b1;
			S_AXI_BRESP_O <= is_mapped(awaddr_ff) ? `CBI_RESP_OKAY : `CBI_RESP_SLVERR;
		end
		else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
			S_AXI_BVALID_O <= 1'b0;
	end
end
// enable register with byte lanes
always @*
begin
	nxt_enable = buffer_irq_enable_ff;
	if (wr_go && awaddr_ff == `CBI_OFF_ENABLE)
	begin
		if (wstrb_ff[0])
			nxt_enable[7:0] = wdata_ff[7:0];
		if (wstrb_ff[1])
			nxt_enable[15:8] = wdata_ff[15:8];
	end
end
always @(posedge SYS_CLK_I)
begin
	if (RST_I)
		buffer_irq_enable_ff <= `CBI_ENABLE_RST;
	else
		buffer_irq_enable_ff <= nxt_enable;
end
// pending flags: read arms, zero write clears per byte lane
always @*
begin
	pend_rd = 16'h0000;
	pend_wr_en = 16'h0000;
	pend_wr_bit = wdata_ff[15:0];
	if (rd_go && S_AXI_ARADDR_I == `CBI_OFF_PENDING)
		pend_rd = 16'hFFFF;
	if (wr_go && awaddr_ff == `CBI_OFF_PENDING)
		pend_wr_en = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
end
genvar gi;
generate
	for (gi = 0; gi < 16; gi = gi + 1)
	begin : g_flag
		cbi_pend_flag u_flag
		(
			.clk_i(SYS_CLK_I),
			.rst_i(RST_I),
			.set_i(BUF_DONE_I[gi]),
			.read_i(pend_rd[gi]),
			.wr_en_i(pend_wr_en[gi]),
			.wr_bit_i(pend_wr_bit[gi]),
			.flag_o(buffer_irq_pending[gi])
		);
	end
endgenerate
// read path
always @*
begin
	fault_confinement_state = {1'b0, ERR_PASSIVE_I};
	case (S_AXI_ARADDR_I)
		`CBI_OFF_ENABLE: rd_value = {16'h0000, buffer_irq_enable_ff};
		`CBI_OFF_PENDING: rd_value = {16'h0000, buffer_irq_pending};
		`CBI_OFF_ERRCNT: rd_value = {16'h0000, TX_ERR_CNT_I, RX_ERR_CNT_I};
		`CBI_OFF_STATUS: rd_value = {22'h000000, TRANSMIT_WARNING_O, RECEIVE_WARNING_O, 2'b00, fault_confinement_state, 4'h0};
		default: rd_value = 32'h00000000;
	endcase
end
always @(posedge SYS_CLK_I)
begin
	if (RST_I)
	begin
		S_AXI_ARREADY_O <= 1'b0;
		S_AXI_RVALID_O <= 1'b0;
		S_AXI_RDATA_O <= 32'h00000000;
		S_AXI_RRESP_O <= `CBI_RESP_OKAY;
	end
	else
	begin
		S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
		if (rd_go)
		begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O <= rd_value;
			S_AXI_RRESP_O <= is_mapped(S_AXI_ARADDR_I) ? `CBI_RESP_OKAY : `CBI_RESP_SLVERR;
		end
		else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
			S_AXI_RVALID_O <= 1'b0;
	end
end
// interrupt request and warnings
always @(posedge SYS_CLK_I)
begin
	if (RST_I)
	begin
		BUF_IRQ_O <= 1'b0;
		TRANSMIT_WARNING_O <= 1'b0;
		RECEIVE_WARNING_O <= 1'b0;
	end
	else
	begin
		BUF_IRQ_O <= |(buffer_irq_pending & buffer_irq_enable_ff);
		TRANSMIT_WARNING_O <= (TX_ERR_CNT_I >= `CBI_WARN_LIMIT);
		RECEIVE_WARNING_O <= (RX_ERR_CNT_I >= `CBI_WARN_LIMIT);
	end
end
endmodule // cbi_top

// ==== cbi_checker.sv ====
// assertion checker on the cbi_top ports
`timescale 1ns/1ps
module cbi_checker
(
	// watched ports
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic [15:0] BUF_DONE_I,
	input wire logic [7:0] RX_ERR_CNT_I,
	input wire logic [7:0] TX_ERR_CNT_I,
	input wire logic BUF_IRQ_O,
	input wire logic TRANSMIT_WARNING_O,
	input wire logic RECEIVE_WARNING_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic [31:0] S_AXI_RDATA_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	a_tx_set: assert property (!$past(RST_I) && $past(TX_ERR_CNT_I) >= 8'h60 |-> TRANSMIT_WARNING_O)
		else $error("tx warning low");
	a_tx_clr: assert property (!$past(RST_I) && $past(TX_ERR_CNT_I) < 8'h60 |-> !TRANSMIT_WARNING_O)
		else $error("tx warning high");
	a_rx_set: assert property (!$past(RST_I) && $past(RX_ERR_CNT_I) >= 8'h60 |-> RECEIVE_WARNING_O)
		else $error("rx warning low");
	a_rx_clr: assert property (!$past(RST_I) && $past(RX_ERR_CNT_I) < 8'h60 |-> !RECEIVE_WARNING_O)
		else $error("rx warning high");
	a_irq_rise: assert property ($rose(BUF_IRQ_O) |-> $past(BUF_DONE_I, 2) != 16'h0000 || $past(S_AXI_BVALID_O))
		else $error("irq without cause");
	a_irq_fall: assert property ($fell(BUF_IRQ_O) |-> $past(S_AXI_BVALID_O))
		else $error("irq dropped without write");
	a_irq_keep: assert property (BUF_IRQ_O && !S_AXI_BVALID_O |=> BUF_IRQ_O)
		else $error("irq not held");
	a_rd_upper: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0000)
		else $error("upper read bits set");
	cover property ($rose(BUF_IRQ_O));
	cover property ($fell(BUF_IRQ_O));
	cover property (TRANSMIT_WARNING_O && !RECEIVE_WARNING_O);
endmodule // cbi_checker
bind cbi_top cbi_checker u_chk (.*);

// ==== cbi_core_model.sv ====
// can core stand-in pulsing buffer completions
`timescale 1ns/1ps
module cbi_core_model
(
	// bench side
	input wire logic clk_i,
	input wire logic fire_i,
	input wire logic [3:0] buf_i,
	// block side
	output logic [15:0] done_o = 16'h0000
);
	always @(posedge clk_i)
	begin
		done_o <= fire_i ? 16'h0001 << buf_i : 16'h0000;
	end
endmodule // cbi_core_model

// ==== tb_can_buffer_irq_and_error_counters.sv ====
// self-checking bench for the buffer irq block
`timescale 1ns/1ps
module tb_can_buffer_irq_and_error_counters;
	logic c = 0, rst = 1, awv = 0, wv = 0, arv = 0, br = 0, rr = 0, fire = 0, pas = 0;
	logic [3:0] awa = 0, ara = 0, ws = 0, bi = 0;
	logic [7:0] rxi = 0, txi = 0;
	logic [31:0] wd = 0, rd;
	logic [1:0] rs;
	wire [15:0] done;
	wire [1:0] bre, rre;
	wire [31:0] rdat;
	wire irq, awr, wrr, arr, bv, rv, txw, rxw;
	integer n_fail = 0, n_compared = 0, cyc = 0;
	initial forever #2.5 c = ~c;
	cbi_core_model u_core (.clk_i(c), .fire_i(fire), .buf_i(bi), .done_o(done));
	cbi_top u_dut (.SYS_CLK_I(c), .RST_I(rst), .BUF_DONE_I(done), .RX_ERR_CNT_I(rxi), .TX_ERR_CNT_I(txi),
		.ERR_PASSIVE_I(pas), .BUF_IRQ_O(irq), .TRANSMIT_WARNING_O(txw), .RECEIVE_WARNING_O(rxw),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
		.S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(bre),
		.S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rre), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr));
	task results;
	begin
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task chk(input [31:0] g, input [31:0] e);
	begin
		n_compared++;
		if (g !== e)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			n_fail++;
		end
	end
	endtask
	task wrt(input [3:0] a, input [31:0] d, input [3:0] s);
		logic ta, tw;
	begin
		{ta, tw} = 2'b00;
		{awa, wd, ws, awv, wv, br} <= {a, d, s, 3'b111};
		while (!(ta && tw))
		begin
			@(posedge c);
			{ta, tw} = {ta | awr, tw | wrr};
			{awv, wv} <= {!ta, !tw};
		end
		do @(posedge c); while (!bv);
		rs = bre;
		br <= 1'b0;
		@(posedge c);
	end
	endtask
	task rc(input [3:0] a, input [31:0] e);
	begin
		{ara, arv, rr} <= {a, 2'b11};
		do @(posedge c); while (!arr);
		arv <= 1'b0;
		do @(posedge c); while (!rv);
		{rd, rs} = {rdat, rre};
		rr <= 1'b0;
		@(posedge c);
		chk(rd, e);
	end
	endtask
	task ev(input [3:0] b);
	begin
		{fire, bi} <= {1'b1, b};
		@(posedge c);
		fire <= 1'b0;
		repeat (3) @(posedge c);
	end
	endtask
	task t_regs;
	begin
		rc(4'h0, 32'h0);
		rc(4'h4, 32'h0);
		wrt(4'h0, 32'hFFFF_AB34, 4'h1);
		rc(4'h0, 32'h34);
		wrt(4'h0, 32'hFFFF_AB00, 4'hE);
		rc(4'h0, 32'hAB34);
		rc(4'h2, 32'h0);
		chk(rs, 32'h2);
		wrt(4'h2, 32'hFFFF, 4'h3);
		chk(rs, 32'h2);
		rc(4'h0, 32'hAB34);
		$display("regs done");
	end
	endtask
	task t_flags;
	begin
		wrt(4'h0, 32'h0201, 4'h3);
		ev(4'h0);
		chk(irq, 32'h1);
		rc(4'h4, 32'h1);
		wrt(4'h4, 32'hFFFF, 4'h3);
		rc(4'h4, 32'h1);
		ev(4'h0);
		wrt(4'h4, 32'h0, 4'h3);
		rc(4'h4, 32'h1);
		wrt(4'h4, 32'h0, 4'h3);
		rc(4'h4, 32'h0);
		chk(irq, 32'h0);
		ev(4'h9);
		wrt(4'h4, 32'h0, 4'h2);
		rc(4'h4, 32'h200);
		wrt(4'h4, 32'h0, 4'h1);
		wrt(4'h4, 32'h0, 4'h2);
		rc(4'h4, 32'h0);
		ev(4'h4);
		chk(irq, 32'h0);
		$display("flags done");
	end
	endtask
	task t_err(input [7:0] r, input [7:0] t, input p);
	begin
		{rxi, txi, pas} <= {r, t, p};
		wrt(4'h8, 32'hFFFF, 4'hF);
		chk(rs, 32'h0);
		rc(4'h8, {t, r});
		rc(4'hC, {t >= 8'h60, r >= 8'h60, 3'b000, p, 4'h0});
		chk({txw, rxw}, {t >= 8'h60, r >= 8'h60});
		$display("errors done");
	end
	endtask
	always @(posedge c)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			results;
		end
	end
	initial
	begin
		repeat (2) @(posedge c);
		rst <= 1'b0;
		t_regs;
		t_flags;
		t_err(8'h5F, 8'h60, 1'b1);
		t_err(8'h60, 8'h5F, 1'b0);
		results;
	end
endmodule // tb_can_buffer_irq_and_error_counters
